// file: rtl/seq_map_defines.svh
// Purpose: constants of the sequence input signal mapper
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   definitions only
`ifndef SEQ_MAP_DEFINES_SVH
`define SEQ_MAP_DEFINES_SVH

// ==========================================================
// register offsets
`define SELECT_A_OFFSET   4'h0
`define ACTIVE_MAP_OFFSET 4'h4
`define RESTART_OFFSET    4'h8
`define SIGNAL_OFFSET     4'hC

// ==========================================================
// reset values and fields
`define SELECT_A_RESET    16'h2100
`define FACTORY_CODES     12'h210
`define MODE_FACTORY      4'h0
`define MODE_PER_SIGNAL   4'h1
`define RESTART_BIT       0
`define TERMINAL_COUNT    7

// ==========================================================
// field codes
`define CODE_LAST_NORMAL  4'h6
`define CODE_FIXED_ON     4'h7
`define CODE_FIXED_OFF    4'h8
`define CODE_FIRST_REV    4'h9

`endif

// file: rtl/seq_map_pkg.sv
// Purpose: types of the sequence input signal mapper
// Assumes: seq_map_defines.svh holds the numbers
// Notes:   none
package seq_map_pkg;

  // ========================================================
  // setting word, digit 3 down to digit 0
  typedef struct packed {
    logic [3:0] prohibit_code;
    logic [3:0] pcon_code;
    logic [3:0] servo_on_code;
    logic [3:0] mode;
  } select_word_s;

  // ========================================================
  // logical control signals
  typedef struct packed {
    logic forward_run_prohibit;
    logic proportional_control_select;
    logic servo_on;
  } seq_signals_s;

  typedef enum logic [1:0] {
    FIELD_SERVO_ON,
    FIELD_PCON,
    FIELD_PROHIBIT
  } field_e;

endpackage : seq_map_pkg

// file: rtl/input_field_decoder.sv
// Purpose: decode one mapping code against the terminals
// Assumes: terminal bit high means input closed
// Notes:   combinational
`timescale 1ns/1ps
`include "seq_map_defines.svh"

module input_field_decoder #(
  parameter bit PROHIBIT_FIELD = 1'b0
) (
  input  wire logic [3:0]                   code,
  input  wire logic [`TERMINAL_COUNT-1:0]   terminal_in,
  output logic                              level
);

  // ========================================================
  // code decode
  logic [3:0] index;
  logic       pin;

  always_comb begin
    index = 4'h0;
    pin   = 1'b0;
    level = 1'b0;
    if (code <= `CODE_LAST_NORMAL) begin
      index = code;
      pin   = terminal_in[index[2:0]];
      level = PROHIBIT_FIELD ? ~pin : pin;
    end else if (code == `CODE_FIXED_ON) begin
      level = 1'b1;
    end else if (code == `CODE_FIXED_OFF) begin
      level = 1'b0;
    end else begin
      index = code - `CODE_FIRST_REV;
      pin   = terminal_in[index[2:0]];
      level = PROHIBIT_FIELD ? pin : ~pin;
    end
  end

endmodule : input_field_decoder

// file: rtl/sequence_input_signal_mapper.sv
// Purpose: route sequence input terminals to control signals
// Assumes: single clock, Avalon-MM slave with waitrequest
// Notes:   routing changes only on reset or restart
`timescale 1ns/1ps
`include "seq_map_defines.svh"

module sequence_input_signal_mapper (
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic [3:0]                   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [3:0]                   byteenable,
  input  wire logic [31:0]                  writedata,
  output logic [31:0]                       readdata,
  output logic                              waitrequest,
  input  wire logic [`TERMINAL_COUNT-1:0]   terminal_in,
  output seq_map_pkg::seq_signals_s         seq_out
);

  // ========================================================
  // bus handshake: one wait cycle per access
  logic ack_reg;
  logic access;
  logic wr_go;
  logic rd_go;

  assign access      = read | write;
  assign waitrequest = access & ~ack_reg;
  assign wr_go       = write & ack_reg;
  assign rd_go       = read & ~ack_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  // ========================================================
  // setting word and restart request
  logic [15:0]                select_a_reg;
  logic                       restart_reg;
  seq_map_pkg::select_word_s  active_map_reg;
  seq_map_pkg::select_word_s  active_map_next;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      select_a_reg <= `SELECT_A_RESET;
    end else if (wr_go && address == `SELECT_A_OFFSET) begin
      if (byteenable[0]) begin
        select_a_reg[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        select_a_reg[15:8] <= writedata[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_go && address == `RESTART_OFFSET &&
                     byteenable[0] && writedata[`RESTART_BIT];
    end
  end

  // ========================================================
  // active routing, loaded only by reset or restart
  always_comb begin
    active_map_next = active_map_reg;
    if (restart_reg) begin
      active_map_next = seq_map_pkg::select_word_s'(select_a_reg);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_map_reg <= seq_map_pkg::select_word_s'(`SELECT_A_RESET);
    end else begin
      active_map_reg <= active_map_next;
    end
  end

  // ========================================================
  // allocation mode and per-field decoding
  logic [11:0] codes;
  logic [2:0]  levels;

  always_comb begin
    if (active_map_reg.mode == `MODE_PER_SIGNAL) begin
      codes = {active_map_reg.prohibit_code, active_map_reg.pcon_code,
               active_map_reg.servo_on_code};
    end else begin
      codes = `FACTORY_CODES;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_field
      input_field_decoder #(
        .PROHIBIT_FIELD (g == int'(seq_map_pkg::FIELD_PROHIBIT))
      ) u_dec (
        .code        (codes[4*g +: 4]),
        .terminal_in (terminal_in),
        .level       (levels[g])
      );
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_out <= '0;
    end else begin
      seq_out.servo_on                    <= levels[0];
      seq_out.proportional_control_select <= levels[1];
      seq_out.forward_run_prohibit        <= levels[2];
    end
  end

  // ========================================================
  // read data
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (address)
        `SELECT_A_OFFSET:   readdata <= {16'h0000, select_a_reg};
        `ACTIVE_MAP_OFFSET: readdata <= {16'h0000, active_map_reg};
        `SIGNAL_OFFSET:     readdata <= {29'h00000000, seq_out};
        default:            readdata <= 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // checks
  a_map_holds: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !restart_reg |=> $stable(active_map_reg))
    else $error("active map changed without restart");

  a_map_loads: assert property (
    @(posedge core_clk) disable iff (!resetn)
    restart_reg |=> active_map_reg == $past(select_a_reg))
    else $error("restart did not load setting word");

  a_factory_mode: assert property (
    @(posedge core_clk) disable iff (!resetn)
    active_map_reg.mode != `MODE_PER_SIGNAL |=>
      seq_out == {!$past(terminal_in[2]), $past(terminal_in[1]),
                  $past(terminal_in[0])})
    else $error("factory allocation not used");

  a_servo_normal: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[3:0] <= 4'h6 |=>
      seq_out.servo_on == $past(terminal_in[codes[2:0]]))
    else $error("servo-on normal polarity wrong");

  a_servo_reverse: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[3:0] >= 4'h9 |=>
      seq_out.servo_on != $past(terminal_in[3'(codes[3:0] - 4'h9)]))
    else $error("servo-on reverse polarity wrong");

  a_servo_fixed: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[3:0] == 4'h7 |=> seq_out.servo_on)
    else $error("servo-on fixed-on wrong");

  a_servo_released: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[3:0] == 4'h8 |=> !seq_out.servo_on)
    else $error("servo-on fixed-off wrong");

  a_pcon_normal: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[7:4] <= 4'h6 |=>
      seq_out.proportional_control_select == $past(terminal_in[codes[6:4]]))
    else $error("proportional select normal polarity wrong");

  a_pcon_reverse: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[7:4] >= 4'h9 |=> seq_out.proportional_control_select !=
      $past(terminal_in[3'(codes[7:4] - 4'h9)]))
    else $error("proportional select reverse polarity wrong");

  a_pcon_fixed: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[7:4] == 4'h7 |=> seq_out.proportional_control_select)
    else $error("proportional select fixed-on wrong");

  a_pcon_released: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[7:4] == 4'h8 |=> !seq_out.proportional_control_select)
    else $error("proportional select fixed-off wrong");

  a_prohibit_normal: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[11:8] <= 4'h6 |=> seq_out.forward_run_prohibit ==
      !$past(terminal_in[codes[10:8]]))
    else $error("forward prohibit normal polarity wrong");

  a_prohibit_reverse: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[11:8] >= 4'h9 |=> seq_out.forward_run_prohibit ==
      $past(terminal_in[3'(codes[11:8] - 4'h9)]))
    else $error("forward prohibit reverse polarity wrong");

  a_prohibit_on: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[11:8] == 4'h7 |=> seq_out.forward_run_prohibit)
    else $error("forward prohibit not forced");

  a_prohibit_off: assert property (
    @(posedge core_clk) disable iff (!resetn)
    codes[11:8] == 4'h8 |=> !seq_out.forward_run_prohibit)
    else $error("forward prohibit not released");

  a_one_wait: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $rose(access) |-> waitrequest ##1 !waitrequest)
    else $error("access not answered after one wait");

endmodule : sequence_input_signal_mapper

// file: dv/terminal_driver.sv
// Purpose: far side model, drives the sequence input terminals
// Assumes: bit high means terminal closed
// Notes:   levels land one clock after the command
`timescale 1ns/1ps

module terminal_driver (
  input  wire logic       core_clk,
  input  wire logic [6:0] level_cmd,
  output logic      [6:0] terminal_in = 7'h00
);
  // ==========================================================
  // terminal levels
  always @(posedge core_clk) begin
    terminal_in <= level_cmd;
  end
endmodule : terminal_driver

// file: dv/sequence_input_signal_mapper_tb_top.sv
// Purpose: self-checking bench of the sequence input signal mapper
// Assumes: one wait cycle per bus access
// Notes:   no random stimulus
`timescale 1ns/1ps
`include "seq_map_defines.svh"
`define CHK(what, exp, got) \
  begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end

module sequence_input_signal_mapper_tb_top;
  logic                      core_clk = 0;
  logic                      resetn = 0;
  logic                      read = 0;
  logic                      write = 0;
  logic [3:0]                address = 4'h0;
  logic [3:0]                byteenable = 4'h0;
  logic [31:0]               writedata = 32'h0;
  logic [31:0]               readdata;
  logic                      waitrequest;
  logic [6:0]                level_cmd = 7'h00;
  logic [6:0]                terminal_in;
  seq_map_pkg::seq_signals_s seq_out;
  int                        check_count = 0;
  int                        mismatches = 0;

  // ==========================================================
  // clock, design, far side
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  sequence_input_signal_mapper DUT (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .terminal_in(terminal_in),
    .seq_out(seq_out));

  terminal_driver far_side (.core_clk(core_clk), .level_cmd(level_cmd),
    .terminal_in(terminal_in));

  // ==========================================================
  // tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic bus(input logic rd, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    address    <= a;
    writedata  <= d;
    byteenable <= 4'hF;
    read       <= rd;
    write      <= !rd;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  function automatic logic exp_level(input logic [3:0] c,
                                     input logic [6:0] t, input logic pro);
    logic v;
    if (c == 4'h7) return 1'b1;
    if (c == 4'h8) return 1'b0;
    v = (c < 4'h7) ? t[c[2:0]] : ~t[3'(c - 4'h9)];
    return pro ? ~v : v;
  endfunction : exp_level

  task automatic check_map(input logic [3:0] s, input logic [3:0] p,
                           input logic [3:0] f);
    logic [6:0]  t;
    logic [2:0]  e;
    logic [31:0] q;
    for (int k = 0; k < 2; k++) begin
      t = k ? 7'h2A : 7'h55;
      e = {exp_level(f, t, 1'b1), exp_level(p, t, 1'b0),
           exp_level(s, t, 1'b0)};
      @(posedge core_clk);
      level_cmd <= t;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("seq_out", e, seq_out)
      bus(1'b1, `SIGNAL_OFFSET, 32'h0, q);
      `CHK("status", {29'h0, e}, q)
    end
  endtask : check_map

  // ==========================================================
  // tests
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b1, `SELECT_A_OFFSET, 32'h0, q);
    `CHK("setting", 32'h2100, q)
    bus(1'b1, `ACTIVE_MAP_OFFSET, 32'h0, q);
    `CHK("active", 32'h2100, q)
    check_map(4'h0, 4'h1, 4'h2);
    $display("test reset done");
    bus(1'b0, `SELECT_A_OFFSET, 32'h9871, q);
    check_map(4'h0, 4'h1, 4'h2);
    bus(1'b1, `SELECT_A_OFFSET, 32'h0, q);
    `CHK("setting", 32'h9871, q)
    $display("test held setting done");
    for (int c = 0; c < 16; c++) begin
      bus(1'b0, `SELECT_A_OFFSET, {16'h0, 4'(c), ~4'(c), 4'(c), 4'h1}, q);
      bus(1'b0, `RESTART_OFFSET, 32'h1, q);
      check_map(4'(c), ~4'(c), 4'(c));
    end
    $display("test codes done");
    bus(1'b0, `SELECT_A_OFFSET, 32'h7870, q);
    bus(1'b0, `RESTART_OFFSET, 32'h1, q);
    check_map(4'h0, 4'h1, 4'h2);
    bus(1'b0, `ACTIVE_MAP_OFFSET, 32'h1234, q);
    bus(1'b1, `ACTIVE_MAP_OFFSET, 32'h0, q);
    `CHK("active", 32'h7870, q)
    bus(1'b1, 4'h2, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, `RESTART_OFFSET, 32'h0, q);
    `CHK("restart", 32'h0, q)
    $display("test factory mode done");
    bus(1'b0, `SELECT_A_OFFSET, 32'h9871, q);
    bus(1'b0, `RESTART_OFFSET, 32'h1, q);
    check_map(4'h7, 4'h8, 4'h9);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b1, `SELECT_A_OFFSET, 32'h0, q);
    `CHK("setting", 32'h2100, q)
    bus(1'b1, `ACTIVE_MAP_OFFSET, 32'h0, q);
    `CHK("active", 32'h2100, q)
    check_map(4'h0, 4'h1, 4'h2);
    $display("test reset in run done");
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
endmodule : sequence_input_signal_mapper_tb_top
